// ### dv/lmi_exec_monitor.sv
// bus and pulse assertions for the literal, move and indirect-store executor
`timescale 1ns/1ps
module lmi_exec_monitor (
    input wire        aclk,
    input wire        aresetn,
    input wire        ce,
    input wire        s_axi_awready,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire        wr_en_q,
    input wire [15:0] wr_addr_q,
    input wire        pc_adv_q,
    input wire        soft_reset_q
);
    default clocking cb @(posedge aclk);
    endclocking
    // a frozen clock enable stretches pulses, so it masks the checks
    default disable iff (!aresetn || !ce);
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
    property p_b_busy;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_b_busy: assert property (p_b_busy) else $error("write taken while answer pending");
    property p_wr_pulse;
        wr_en_q |=> !wr_en_q;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("store pulse too long");
    property p_wr_pc;
        wr_en_q |-> pc_adv_q;
    endproperty
    a_wr_pc: assert property (p_wr_pc) else $error("store not in one cycle");
    property p_wr_cause;
        !s_axi_bvalid |=> !wr_en_q;
    endproperty
    a_wr_cause: assert property (p_wr_cause) else $error("store without opcode");
    property p_wr_hold;
        wr_en_q |=> $stable(wr_addr_q);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("store address moved");
    property p_pc_pulse;
        pc_adv_q |=> !pc_adv_q;
    endproperty
    a_pc_pulse: assert property (p_pc_pulse) else $error("advance pulse too long");
    property p_pc_cause;
        pc_adv_q |-> $past(s_axi_bvalid);
    endproperty
    a_pc_cause: assert property (p_pc_cause) else $error("advance without opcode");
    property p_sr_pulse;
        soft_reset_q |=> !soft_reset_q;
    endproperty
    a_sr_pulse: assert property (p_sr_pulse) else $error("reset pulse too long");
endmodule
bind literal_move_indirect_exec lmi_exec_monitor u_mon (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .wr_en_q(wr_en_q), .wr_addr_q(wr_addr_q),
    .pc_adv_q(pc_adv_q), .soft_reset_q(soft_reset_q)
);

// ### dv/tb_literal_move_indirect_exec.sv
// self-checking bench for the literal, move and indirect-store executor
`timescale 1ns/1ps
`include "lmi_consts.vh"
module tb_literal_move_indirect_exec;
    logic        aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, wr_en_q, pc_adv_q, soft_reset_q;
    logic [6:0]  awaddr, araddr, f;
    logic [31:0] wdata, rdata, q;
    logic [1:0]  bresp, rresp, m;
    logic [15:0] wr_addr_q, wa, p, np;
    logic [7:0]  wr_data_q, wd, w;
    logic [5:0]  k;
    logic [4:0]  bk;
    int          fail_count = 0, samples_checked = 0, wr_cnt = 0, pc_cnt = 0, sr_cnt = 0, i, c;
    literal_move_indirect_exec dut (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .wr_en_q(wr_en_q), .wr_addr_q(wr_addr_q),
        .wr_data_q(wr_data_q), .pc_adv_q(pc_adv_q), .soft_reset_q(soft_reset_q)
    );
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (wr_en_q) begin
            wr_cnt++;
            wa = wr_addr_q;
            wd = wr_data_q;
        end
        if (pc_adv_q) pc_cnt++;
        if (soft_reset_q) sr_cnt++;
    end
    function automatic logic [6:0] ra(input logic [4:0] idx);
        return {idx, 2'b00};
    endfunction
    task automatic end_sim;
        $display("checks %0d errors %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic axw(input logic [6:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n == 40) begin
            fail_count++;
            end_sim();
        end
        chk(32'(bresp), 32'(er));
    endtask
    task automatic axr(input logic [6:0] a, input logic [1:0] er, output logic [31:0] d);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        d = rdata;
        if (n == 40) begin
            fail_count++;
            end_sim();
        end
        chk(32'(rresp), 32'(er));
    endtask
    task automatic rd(input logic [4:0] idx, input logic [31:0] e);
        axr(ra(idx), `AXI_OKAY, q);
        chk(q, e);
    endtask
    task automatic ex(input logic [13:0] op);
        int c0;
        c0 = pc_cnt;
        axw(7'h00, {18'h0, op}, `AXI_OKAY);
        repeat (2) @(posedge aclk);
        chk(32'(pc_cnt - c0), 32'h1);
    endtask
    // store opcode: exactly one memory write of work to the given address
    task automatic st(input logic [13:0] op, input logic [15:0] ea);
        int c0;
        c0 = wr_cnt;
        ex(op);
        chk(32'(wr_cnt - c0), 32'h1);
        chk({8'h0, wd, wa}, {8'h0, w, ea});
    endtask
    initial begin
        aresetn = 1'b0;
        ce = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata} = 46'h0;
        void'($urandom(32'hE692));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`REG_WORK, 32'h0);
        rd(`REG_OPTION, 32'hFF);
        rd(`REG_CTRL, 32'h1);
        // status belongs to software; every later instruction before the software reset must leave it alone
        axw(ra(`REG_STATUS), 32'hA5, `AXI_OKAY);
        for (i = 0; i < 6; i++) begin
            bk = (i == 0) ? 5'h1F : 5'($urandom);
            ex(`OP_LB | 14'(bk));
            rd(`REG_BANK, 32'(bk));
            f = (i == 0) ? 7'h7F : 7'($urandom);
            ex(`OP_LP | 14'(f));
            rd(`REG_PAGE, 32'(f));
            w = (i == 0) ? 8'hFF : 8'($urandom);
            ex(`OP_LW | 14'(w));
            rd(`REG_WORK, 32'(w));
            ex(`OP_OPTION);
            rd(`REG_OPTION, 32'(w));
            f = (i == 0) ? 7'h7F : 7'h02 + 7'($urandom % 126);
            st(`OP_WF | 14'(f), {bk, 4'h0, f});
            rd(`REG_WB, {8'h0, w, bk, 4'h0, f});
            p = 16'($urandom);
            axw(ra(i[0] ? `REG_PTR1 : `REG_PTR0), 32'(p), `AXI_OKAY);
            st(`OP_WF | 14'(i[0]), p);
        end
        for (i = 0; i < 8; i++) begin
            p = (i < 2) ? 16'hFFFF : ((i < 4) ? 16'h0000 : 16'($urandom));
            m = i[1:0];
            axw(ra(i[2] ? `REG_PTR1 : `REG_PTR0), 32'(p), `AXI_OKAY);
            np = m[0] ? p - 16'h1 : p + 16'h1;
            st(`OP_WI_MODE | {11'h0, i[2], m}, m[1] ? p : np);
            rd(i[2] ? `REG_PTR1 : `REG_PTR0, 32'(np));
        end
        for (i = 0; i < 4; i++) begin
            k = (i == 0) ? 6'h20 : ((i == 1) ? 6'h1F : 6'($urandom));
            p = 16'($urandom);
            axw(ra(i[0] ? `REG_PTR1 : `REG_PTR0), 32'(p), `AXI_OKAY);
            st(`OP_WIK | {7'h0, i[0], k}, p + {{10{k[5]}}, k});
            rd(i[0] ? `REG_PTR1 : `REG_PTR0, 32'(p));
        end
        c = wr_cnt;
        ex(`OP_NOP);
        chk(32'(wr_cnt - c), 32'h0);
        rd(`REG_WORK, 32'(w));
        rd(`REG_STATUS, 32'hA5);
        axw(7'h28, 32'h1, `AXI_SLVERR);
        axr(7'h28, `AXI_SLVERR, q);
        chk(q, 32'h0);
        axw(ra(`REG_BANK), 32'h15, `AXI_OKAY);
        axw(ra(`REG_PAGE), 32'h5A, `AXI_OKAY);
        axw(ra(`REG_OPTION), 32'h3C, `AXI_OKAY);
        // a frozen clock enable must keep every register as it was
        ce <= 1'b0;
        repeat (3) @(posedge aclk);
        ce <= 1'b1;
        rd(`REG_BANK, 32'h15);
        rd(`REG_PAGE, 32'h5A);
        rd(`REG_OPTION, 32'h3C);
        c = sr_cnt;
        axw(7'h00, {18'h0, `OP_RESET}, `AXI_OKAY);
        repeat (2) @(posedge aclk);
        chk(32'(sr_cnt - c), 32'h1);
        rd(`REG_CTRL, 32'h0);
        rd(`REG_WORK, 32'h0);
        rd(`REG_OPTION, 32'hFF);
        rd(`REG_BANK, 32'h0);
        rd(`REG_PAGE, 32'h0);
        rd(`REG_PTR1, 32'h0);
        axw(ra(`REG_CTRL), 32'h1, `AXI_OKAY);
        rd(`REG_CTRL, 32'h1);
        end_sim();
    end
endmodule

// ### hw/exec_regs.v
// small register bank for the executor's software-visible words
`timescale 1ns/1ps
`include "lmi_consts.vh"
module exec_regs #(
    parameter WIDTH = 16,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             aclk,
    input  wire             aresetn,
    input  wire             ce,
    input  wire             we,
    input  wire [AW-1:0]    waddr,
    input  wire [WIDTH-1:0] wdata,
    input  wire [AW-1:0]    raddr,
    output reg  [WIDTH-1:0] rdata
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    integer i;
    always @(posedge aclk) begin
        if (!aresetn) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem[i] <= {WIDTH{1'b0}};
            end
            rdata <= {WIDTH{1'b0}};
        end else if (ce) begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata <= mem[raddr];
        end
    end
endmodule

// ### hw/literal_move_indirect_exec.v
// executor for literal loads, work stores, indirect store, option and reset
`timescale 1ns/1ps
`include "lmi_consts.vh"
// Behaviour
// RL1 - bank literal load writes 5-bit immediate to bank select, flags untouched
// RL2 - page latch load writes 7-bit immediate to pc high latch, flags untouched
// RL3 - work literal load puts 8-bit immediate in work register, one cycle
// RL4 - store work to file writes work to 7-bit address in one cycle
// RL5 - two-bit mode selects pre/post increment or decrement of pointer
// RL6 - effective address is pointer (post modes), pointer +1, -1 or +signed offset; offset keeps pointer
// RL7 - window register accesses are redirected to address held in pointer
// RL8 - pointers are 16 bits and wrap at both ends
// RL9 - pointer updates never change status flags
// RL10 - option load copies work into option register in one cycle
// RL11 - software reset acts as full reset and clears reset-instruction flag
// RL12 - no-operation changes nothing but advancing the program counter
module literal_move_indirect_exec (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        ce,
    input  wire [6:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [6:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         wr_en_q,
    output reg  [15:0] wr_addr_q,
    output reg  [7:0]  wr_data_q,
    output reg         pc_adv_q,
    output reg         soft_reset_q
);
    reg  [13:0] opcode_q;
    reg  [7:0]  work_q;
    reg  [4:0]  bank_select_reg_q;
    reg  [6:0]  pc_high_latch_q;
    reg  [7:0]  option_q;
    reg         reset_instruction_flag_q;
    reg  [7:0]  status_q;
    reg         aw_hold_q;
    reg         w_hold_q;
    reg  [4:0]  aw_idx_q;
    reg  [31:0] w_data_q;
    reg  [3:0]  w_strb_q;
    reg         exec_q;
    reg         rd_pend_q;
    reg         rd_fetch_q;
    reg  [4:0]  rd_idx_q;
    wire [15:0] ptr_rdata;
    wire        ptr_we;
    wire [1:0]  ptr_waddr;
    wire [15:0] ptr_wdata;
    localparam  PTR_DEPTH = 4;
    localparam  PTR_AW    = 2;
    wire [1:0]  ptr_raddr;
    wire        bank_rstn;
    reg  [15:0] ptr_shadow_q [0:1];
    reg  [15:0] eff_addr;
    reg  [15:0] ptr_next;
    reg         ptr_upd;
    reg         sel;
    reg  [15:0] ptr_cur;
    reg  [15:0] koff;
    wire        bus_wr = aw_hold_q && w_hold_q && !s_axi_bvalid;
    wire        sw_wr  = bus_wr && (aw_idx_q == `REG_PTR0 || aw_idx_q == `REG_PTR1);
    wire        is_wi  = (opcode_q & `OP_WI_MASK) == `OP_WI_MODE;
    wire        is_wik = (opcode_q & `OP_WIK_MASK) == `OP_WIK;
    // pointers persist in the bank, a copy is kept for same-cycle arithmetic
    assign ptr_we    = sw_wr || (exec_q && ptr_upd);
    assign ptr_waddr = sw_wr ? {1'b0, aw_idx_q == `REG_PTR1} : {1'b0, sel};
    assign ptr_wdata = sw_wr ? w_data_q[15:0] : ptr_next;
    // soft reset clears the pointer bank too, so read-back agrees with the shadow
    assign bank_rstn = aresetn && !soft_reset_q;
    // pointer n sits at bank entry n; the upper entries stay unused
    assign ptr_raddr = {1'b0, rd_idx_q == `REG_PTR1};
    exec_regs #(.WIDTH(16), .DEPTH(PTR_DEPTH), .AW(PTR_AW)) u_ptr (
        .aclk    (aclk),
        .aresetn (bank_rstn),
        .ce      (ce),
        .we      (ptr_we),
        .waddr   (ptr_waddr),
        .wdata   (ptr_wdata),
        .raddr   (ptr_raddr),
        .rdata   (ptr_rdata)
    );
    always @* begin
        sel      = is_wik ? opcode_q[6] : opcode_q[2];
        ptr_cur  = ptr_shadow_q[sel];
        koff     = {{10{opcode_q[5]}}, opcode_q[5:0]};
        eff_addr = ptr_cur;
        ptr_next = ptr_cur;
        ptr_upd  = 1'b0;
        if (is_wik) begin
            eff_addr = ptr_cur + koff; // RL6 RL8
        end else if (is_wi) begin
            ptr_upd = 1'b1;
            case (opcode_q[1:0]) // RL5
                `IDX_PREINC: begin
                    ptr_next = ptr_cur + `PTR_ONE; // RL8
                    eff_addr = ptr_next; // RL6
                end
                `IDX_PREDEC: begin
                    ptr_next = ptr_cur - `PTR_ONE;
                    eff_addr = ptr_next; // RL6
                end
                `IDX_POSTINC: begin
                    ptr_next = ptr_cur + `PTR_ONE;
                end
                `IDX_POSTDEC: begin
                    ptr_next = ptr_cur - `PTR_ONE;
                end
                default: begin
                    ptr_next = ptr_cur;
                end
            endcase
        end
    end
    always @(posedge aclk) begin
        if (!aresetn || soft_reset_q) begin
            ptr_shadow_q[0] <= `RST_PTR;
            ptr_shadow_q[1] <= `RST_PTR;
        end else if (ce) begin
            if (sw_wr) begin
                ptr_shadow_q[aw_idx_q == `REG_PTR1] <= w_data_q[15:0];
            end else if (exec_q && ptr_upd) begin
                ptr_shadow_q[sel] <= ptr_next; // RL9
            end
        end
    end
    // execution path, one instruction per cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            reset_instruction_flag_q <= `RSTFLAG_RESET;
        end else if (ce) begin
            if (exec_q && opcode_q == `OP_RESET) begin
                reset_instruction_flag_q <= 1'b0; // RL11
            end else if (bus_wr && aw_idx_q == `REG_CTRL && w_data_q[`CTRL_RSTFLAG_SET]) begin
                reset_instruction_flag_q <= 1'b1;
            end
        end
    end
    always @(posedge aclk) begin
        if (!aresetn || soft_reset_q) begin // RL11
            work_q            <= `RST_BYTE;
            bank_select_reg_q <= 5'h00;
            pc_high_latch_q   <= 7'h00;
            option_q          <= `OPT_RESET;
            status_q          <= `RST_BYTE;
            wr_en_q           <= 1'b0;
            wr_addr_q         <= `RST_PTR;
            wr_data_q         <= `RST_BYTE;
            pc_adv_q          <= 1'b0;
            soft_reset_q      <= 1'b0;
        end else if (ce) begin
            wr_en_q  <= 1'b0;
            pc_adv_q <= exec_q; // RL12
            if (bus_wr && aw_idx_q == `REG_WORK && w_strb_q[0]) begin
                work_q <= w_data_q[7:0];
            end
            if (bus_wr && aw_idx_q == `REG_STATUS && w_strb_q[0]) begin
                status_q <= w_data_q[7:0];
            end
            // software may preset these; an instruction never shares the cycle
            if (bus_wr && aw_idx_q == `REG_BANK && w_strb_q[0]) begin
                bank_select_reg_q <= w_data_q[4:0];
            end
            if (bus_wr && aw_idx_q == `REG_PAGE && w_strb_q[0]) begin
                pc_high_latch_q <= w_data_q[6:0];
            end
            if (bus_wr && aw_idx_q == `REG_OPTION && w_strb_q[0]) begin
                option_q <= w_data_q[7:0];
            end
            if (exec_q) begin
                // status_q is never written here: of this group only the reset instruction touches flags, through soft_reset_q
                if (opcode_q == `OP_NOP) begin
                    wr_en_q <= 1'b0; // RL12
                end else if (opcode_q == `OP_RESET) begin
                    soft_reset_q <= 1'b1; // RL11
                end else if (opcode_q == `OP_OPTION) begin
                    option_q <= work_q; // RL10
                end else if ((opcode_q & `OP_LB_MASK) == `OP_LB) begin
                    bank_select_reg_q <= opcode_q[4:0]; // RL1
                end else if ((opcode_q & `OP_LP_MASK) == `OP_LP) begin
                    pc_high_latch_q <= opcode_q[6:0]; // RL2
                end else if ((opcode_q & `OP_LW_MASK) == `OP_LW) begin
                    work_q <= opcode_q[7:0]; // RL3
                end else if ((opcode_q & `OP_WF_MASK) == `OP_WF) begin
                    wr_en_q   <= 1'b1; // RL4
                    wr_data_q <= work_q;
                    if (opcode_q[6:0] == `WIN0_ADDR || opcode_q[6:0] == `WIN1_ADDR) begin
                        wr_addr_q <= ptr_shadow_q[opcode_q[0]]; // RL7
                    end else begin
                        wr_addr_q <= {bank_select_reg_q, 4'h0, opcode_q[6:0]};
                    end
                end else if (is_wi || is_wik) begin
                    wr_en_q   <= 1'b1; // RL7
                    wr_addr_q <= eff_addr; // RL6
                    wr_data_q <= work_q;
                end
            end
        end
    end
    // axi4-lite slave; a write to the opcode word with both low strobes set issues one instruction
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `AXI_OKAY;
            aw_hold_q     <= 1'b0;
            w_hold_q      <= 1'b0;
            aw_idx_q      <= 5'h00;
            w_data_q      <= 32'h00000000;
            w_strb_q      <= 4'h0;
            opcode_q      <= 14'h0000;
            exec_q        <= 1'b0;
        end else if (ce) begin
            exec_q <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_idx_q      <= s_axi_awaddr[`ADDR_MSB:`ADDR_LSB];
                aw_hold_q     <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                w_hold_q     <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (bus_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_idx_q > `REG_CTRL) ? `AXI_SLVERR : `AXI_OKAY;
                if (aw_idx_q == `REG_OPCODE && (&w_strb_q[1:0])) begin
                    opcode_q <= w_data_q[13:0];
                    exec_q   <= 1'b1;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_hold_q     <= 1'b0;
                w_hold_q      <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `AXI_OKAY;
            rd_pend_q     <= 1'b0;
            rd_idx_q      <= 5'h00;
            rd_fetch_q    <= 1'b0;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                rd_idx_q      <= s_axi_araddr[`ADDR_MSB:`ADDR_LSB];
                rd_pend_q     <= 1'b1;
            end
            // one wait cycle so the bank's registered read has caught up with rd_idx_q
            if (rd_pend_q) begin
                rd_pend_q  <= 1'b0;
                rd_fetch_q <= 1'b1;
            end
            if (rd_fetch_q) begin
                rd_fetch_q   <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= (rd_idx_q > `REG_CTRL) ? `AXI_SLVERR : `AXI_OKAY;
                case (rd_idx_q)
                    `REG_OPCODE: s_axi_rdata <= {18'h00000, opcode_q};
                    `REG_WORK:   s_axi_rdata <= {24'h000000, work_q};
                    `REG_BANK:   s_axi_rdata <= {27'h0000000, bank_select_reg_q};
                    `REG_PAGE:   s_axi_rdata <= {25'h0000000, pc_high_latch_q};
                    `REG_OPTION: s_axi_rdata <= {24'h000000, option_q};
                    `REG_PTR0:   s_axi_rdata <= {16'h0000, ptr_rdata};
                    `REG_PTR1:   s_axi_rdata <= {16'h0000, ptr_rdata};
                    `REG_STATUS: s_axi_rdata <= {24'h000000, status_q};
                    `REG_WB:     s_axi_rdata <= {8'h00, wr_data_q, wr_addr_q};
                    `REG_CTRL:   s_axi_rdata <= {31'h00000000, reset_instruction_flag_q};
                    default:     s_axi_rdata <= 32'h00000000;
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule

// ### inc/lmi_consts.vh
// constants for the literal, move and indirect-store executor
`ifndef LMI_CONSTS_VH
`define LMI_CONSTS_VH
`define OPC_W            14
`define OP_NOP           14'h0000
`define OP_RESET         14'h0001
`define OP_OPTION        14'h0062
`define OP_WI_MASK       14'h3FF8
`define OP_WI_MODE       14'h0018
`define OP_WF_MASK       14'h3F80
`define OP_WF            14'h0080
`define OP_LB_MASK       14'h3FE0
`define OP_LB            14'h0020
`define OP_LP_MASK       14'h3F80
`define OP_LP            14'h3180
`define OP_LW_MASK       14'h3F00
`define OP_LW            14'h3000
`define OP_WIK_MASK      14'h3F80
`define OP_WIK           14'h3F80
`define IDX_PREINC       2'h0
`define IDX_PREDEC       2'h1
`define IDX_POSTINC      2'h2
`define IDX_POSTDEC      2'h3
`define PTR_ONE          16'h0001
`define RST_BYTE         8'h00
`define RST_PTR          16'h0000
`define OPT_RESET        8'hFF
`define RSTFLAG_RESET    1'h1
`define WIN0_ADDR        7'h00
`define WIN1_ADDR        7'h01
`define REG_OPCODE       5'h00
`define REG_WORK         5'h01
`define REG_BANK         5'h02
`define REG_PAGE         5'h03
`define REG_OPTION       5'h04
`define REG_PTR0         5'h05
`define REG_PTR1         5'h06
`define REG_STATUS       5'h07
`define REG_WB           5'h08
`define REG_CTRL         5'h09
`define CTRL_RSTFLAG_SET 0
`define AXI_OKAY         2'h0
`define AXI_SLVERR       2'h2
`define ADDR_LSB         2
`define ADDR_MSB         6
`endif
